// File: rtl/strobe_ctrl_pkg.sv
// Constants shared by the external bus strobe control block.
package strobe_ctrl_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 16;
	localparam int          SYNC_STAGES     = 3;
	localparam int          READ_FN_BIT     = 15;
	localparam logic [15:0] MODE_RESET      = 16'h0000;
	localparam logic [1:0]  SPACE_PROG      = 2'h0;
	localparam logic [1:0]  SPACE_DATA      = 2'h1;
	localparam logic [1:0]  SPACE_IO        = 2'h2;
	localparam int          SEL_PROG        = 0;
	localparam int          SEL_DATA        = 1;
	localparam int          SEL_IO          = 2;
	localparam logic [2:0]  SEL_NONE        = 3'h7;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_ADDR   = 6'h02,
		ST_STROBE = 6'h04,
		ST_END    = 6'h08,
		ST_HFLOAT = 6'h10,
		ST_HACK   = 6'h20
	} bus_state_t;
endpackage

// File: rtl/pin_sync.sv
// Three-stage pin synchroniser that passes a change once stages two and three agree.
`timescale 1ns/100ps
module pin_sync #(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!nrst) begin
					stage1_ff[i] <= INIT[i];
					stage2_ff[i] <= INIT[i];
					stage3_ff[i] <= INIT[i];
					syncOut[i]   <= INIT[i];
				end else begin
					stage1_ff[i] <= pinIn[i];
					stage2_ff[i] <= stage1_ff[i];
					stage3_ff[i] <= stage2_ff[i];
					if (stage2_ff[i] == stage3_ff[i]) begin
						syncOut[i] <= stage3_ff[i];
					end
				end
			end
		end
	endgenerate
endmodule

// File: rtl/external_bus_strobe_control.sv
// External bus strobe, select, multiprocessing and branch-input control.
//
// How it works
// - Read strobe goes low for every external program, data and I/O read.
// - Mode bit 15 set puts inverted direction on the read pin, else read strobe.
// - Data bus driven from write strobe falling edge; partner latches on rising edge.
// - Write strobe pulses low for every external write in any space.
// - Bus cycle strobe is high except during an external bus cycle.
// - Global bus request goes low whenever a global data access begins.
// - On hold, float address, data and controls first, then acknowledge hold.
// - External flag is a latched output that software sets or clears.
// - Branch op takes its target when the branch input is low, else sequential.
// - Output float low puts all strobes, requests and flag in high impedance.
// - Not-ready partner holds ready low; cycle waits, rechecking every cycle.
// - Direction stays high for reads and goes low only during a write.
// - Space selects stay high except the one matching the current access.
`timescale 1ns/100ps
module external_bus_strobe_control (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        reqValid,
	input  wire logic        reqWrite,
	input  wire logic [1:0]  reqSpace,
	input  wire logic        reqGlobal,
	input  wire logic [15:0] reqAddr,
	input  wire logic [15:0] reqWrData,
	output logic             reqAccept,
	output logic             reqDone,
	output logic [15:0]      rdData,
	input  wire logic        modeWrite,
	input  wire logic [15:0] modeWrData,
	output logic [15:0]      modeReg,
	input  wire logic        flagSet,
	input  wire logic        flagClear,
	input  wire logic        branchOp,
	input  wire logic [15:0] branchTarget,
	input  wire logic [15:0] seqAddr,
	output logic             branchValid,
	output logic             branchTaken,
	output logic [15:0]      nextAddr,
	input  wire logic        ready,
	input  wire logic        holdReq_n,
	input  wire logic        output_float_n,
	input  wire logic        branch_condition_in_n,
	input  wire logic [15:0] dataIn,
	output logic [15:0]      dataOut,
	output logic             dataOe,
	output logic [15:0]      addrOut,
	output logic             addrOe,
	output logic             readPinOut,
	output logic             write_strobe_n,
	output logic             bus_cycle_strobe_n,
	output logic             transfer_direction,
	output logic             program_space_select_n,
	output logic             data_space_select_n,
	output logic             io_space_select_n,
	output logic             memCtrlOe,
	output logic             global_bus_request_n,
	output logic             busReqOe,
	output logic             hold_acknowledge_n,
	output logic             holdAckOe,
	output logic             external_flag_out,
	output logic             flagOe
);
	// ----------------------------------------------------------------
	// Decoding functions
	// ----------------------------------------------------------------
	// Returns the active-low select pattern for a space.
	function automatic logic [2:0] space_sel_n(input logic [1:0] space);
		logic [2:0] sel;
		sel = strobe_ctrl_pkg::SEL_NONE;
		case (space)
			strobe_ctrl_pkg::SPACE_PROG: sel[strobe_ctrl_pkg::SEL_PROG] = 1'b0;
			strobe_ctrl_pkg::SPACE_DATA: sel[strobe_ctrl_pkg::SEL_DATA] = 1'b0;
			strobe_ctrl_pkg::SPACE_IO:   sel[strobe_ctrl_pkg::SEL_IO]   = 1'b0;
			default:                     sel = strobe_ctrl_pkg::SEL_NONE;
		endcase
		return sel;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [19:0] pinSync;
	logic        readySync;
	logic        holdReqSync;
	logic        floatSync;
	logic        bioSync;
	logic [15:0] dataSync;

	pin_sync #(
		.WIDTH (20),
		.INIT  (20'hb0000)
	) i_pin_sync (
		.clk     (clk),
		.nrst    (nrst),
		.pinIn   ({ready, ~holdReq_n, output_float_n, branch_condition_in_n, dataIn}),
		.syncOut (pinSync)
	);

	assign readySync   = pinSync[19];
	assign holdReqSync = pinSync[18];
	assign floatSync   = pinSync[17];
	assign bioSync     = pinSync[16];
	assign dataSync    = pinSync[15:0];

	// ----------------------------------------------------------------
	// Bus cycle state machine
	// ----------------------------------------------------------------
	strobe_ctrl_pkg::bus_state_t state_ff;
	strobe_ctrl_pkg::bus_state_t nxt_state;
	logic                        write_ff;
	logic [1:0]                  space_ff;
	logic                        global_ff;
	logic [15:0]                 wrData_ff;
	logic [15:0]                 addr_ff;
	logic                        take;
	logic                        finish;

	assign take   = (state_ff == strobe_ctrl_pkg::ST_IDLE) && reqValid && !holdReqSync;
	assign finish = (state_ff == strobe_ctrl_pkg::ST_STROBE) && readySync;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			strobe_ctrl_pkg::ST_IDLE: begin
				if (holdReqSync) begin
					nxt_state = strobe_ctrl_pkg::ST_HFLOAT;
				end else if (reqValid) begin
					nxt_state = strobe_ctrl_pkg::ST_ADDR;
				end
			end
			strobe_ctrl_pkg::ST_ADDR:   nxt_state = strobe_ctrl_pkg::ST_STROBE;
			strobe_ctrl_pkg::ST_STROBE: begin
				if (finish) begin
					nxt_state = strobe_ctrl_pkg::ST_END;
				end
			end
			strobe_ctrl_pkg::ST_END:    nxt_state = strobe_ctrl_pkg::ST_IDLE;
			strobe_ctrl_pkg::ST_HFLOAT: begin
				nxt_state = holdReqSync ? strobe_ctrl_pkg::ST_HACK : strobe_ctrl_pkg::ST_IDLE;
			end
			strobe_ctrl_pkg::ST_HACK: begin
				if (!holdReqSync) begin
					nxt_state = strobe_ctrl_pkg::ST_IDLE;
				end
			end
			default:                    nxt_state = strobe_ctrl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff <= strobe_ctrl_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			write_ff  <= 1'b0;
			space_ff  <= strobe_ctrl_pkg::SPACE_PROG;
			global_ff <= 1'b0;
			wrData_ff <= 16'h0000;
			addr_ff   <= 16'h0000;
		end else if (take) begin
			write_ff  <= reqWrite;
			space_ff  <= reqSpace;
			global_ff <= reqGlobal && (reqSpace == strobe_ctrl_pkg::SPACE_DATA);
			wrData_ff <= reqWrData;
			addr_ff   <= reqAddr;
		end
	end

	// ----------------------------------------------------------------
	// Next pin values, decoded from the next state
	// ----------------------------------------------------------------
	logic inCycle;
	logic inStrobe;
	logic inHold;
	logic nxtWrite;
	logic nxtRd_n;
	logic nxtWe_n;
	logic nxtStrb_n;
	logic nxtRw;
	logic nxtDataOe;
	logic nxtBr_n;
	logic nxtReadPin;
	logic [2:0] nxtSel_n;
	logic busOe;

	assign inStrobe   = (nxt_state == strobe_ctrl_pkg::ST_STROBE);
	assign inCycle    = (nxt_state == strobe_ctrl_pkg::ST_ADDR) || inStrobe;
	assign inHold     = (nxt_state == strobe_ctrl_pkg::ST_HFLOAT)
		|| (nxt_state == strobe_ctrl_pkg::ST_HACK);
	assign nxtWrite   = take ? reqWrite : write_ff;
	assign nxtStrb_n  = !inCycle;
	assign nxtRd_n    = !(inStrobe && !nxtWrite);
	assign nxtWe_n    = !(inStrobe && nxtWrite);
	assign nxtRw      = !((inCycle || nxt_state == strobe_ctrl_pkg::ST_END) && nxtWrite);
	assign nxtDataOe  = nxtWrite && (inStrobe || nxt_state == strobe_ctrl_pkg::ST_END);
	assign nxtSel_n   = (inCycle || nxt_state == strobe_ctrl_pkg::ST_END)
		? space_sel_n(take ? reqSpace : space_ff) : strobe_ctrl_pkg::SEL_NONE;
	assign nxtBr_n    = !((inCycle || nxt_state == strobe_ctrl_pkg::ST_END)
		&& (take ? (reqGlobal && reqSpace == strobe_ctrl_pkg::SPACE_DATA) : global_ff));
	assign nxtReadPin = modeReg[strobe_ctrl_pkg::READ_FN_BIT] ? !nxtRw : nxtRd_n;
	assign busOe      = floatSync && !inHold;

	// ----------------------------------------------------------------
	// Pin registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			readPinOut             <= 1'b1;
			write_strobe_n         <= 1'b1;
			bus_cycle_strobe_n     <= 1'b1;
			transfer_direction     <= 1'b1;
			{io_space_select_n, data_space_select_n, program_space_select_n} <= 3'h7;
			global_bus_request_n   <= 1'b1;
			dataOe                 <= 1'b0;
			memCtrlOe              <= 1'b0;
			addrOe                 <= 1'b0;
			busReqOe               <= 1'b0;
			hold_acknowledge_n     <= 1'b1;
			holdAckOe              <= 1'b0;
			flagOe                 <= 1'b0;
			dataOut                <= 16'h0000;
			addrOut                <= 16'h0000;
		end else begin
			readPinOut             <= nxtReadPin;
			write_strobe_n         <= nxtWe_n;
			bus_cycle_strobe_n     <= nxtStrb_n;
			transfer_direction     <= nxtRw;
			{io_space_select_n, data_space_select_n, program_space_select_n} <= nxtSel_n;
			global_bus_request_n   <= nxtBr_n;
			dataOe                 <= nxtDataOe && busOe;
			memCtrlOe              <= busOe;
			addrOe                 <= busOe;
			busReqOe               <= busOe;
			hold_acknowledge_n     <= !(nxt_state == strobe_ctrl_pkg::ST_HACK);
			holdAckOe              <= floatSync;
			flagOe                 <= floatSync;
			dataOut                <= take ? reqWrData : wrData_ff;
			addrOut                <= take ? reqAddr : addr_ff;
		end
	end

	// ----------------------------------------------------------------
	// Core handshake, mode register, flag and branch
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			reqAccept         <= 1'b0;
			reqDone           <= 1'b0;
			rdData            <= 16'h0000;
			modeReg           <= strobe_ctrl_pkg::MODE_RESET;
			external_flag_out <= 1'b0;
			branchValid       <= 1'b0;
			branchTaken       <= 1'b0;
			nextAddr          <= 16'h0000;
		end else begin
			reqAccept <= take;
			reqDone   <= finish;
			if (finish && !write_ff) begin
				rdData <= dataSync;
			end
			if (modeWrite) begin
				modeReg <= modeWrData;
			end
			if (flagSet) begin
				external_flag_out <= 1'b1;
			end else if (flagClear) begin
				external_flag_out <= 1'b0;
			end
			branchValid <= branchOp;
			branchTaken <= branchOp && !bioSync;
			nextAddr    <= (branchOp && !bioSync) ? branchTarget : seqAddr;
		end
	end
endmodule

// File: test/ext_mem_model.sv
// Behavioural external memory that answers bus cycles with wait states.
`timescale 1ns/100ps
module ext_mem_model (
	input  wire logic        clk,
	input  wire logic        bus_cycle_strobe_n,
	input  wire logic        write_strobe_n,
	input  wire logic        dataOe,
	input  wire logic [15:0] addrOut,
	input  wire logic [15:0] dataOut,
	input  wire logic [3:0]  waitCycles,
	output logic             ready,
	output logic      [15:0] dataIn,
	output logic      [15:0] wrCapt
);
	logic [3:0] cnt;
	initial begin
		ready = 1'b0;
		dataIn = 16'h0000;
		cnt = 4'h0;
	end
	// Ready stays low until the wait count has run out in each cycle.
	always @(posedge clk) begin
		cnt <= bus_cycle_strobe_n ? 4'h0 : cnt + 4'h1;
		ready <= !bus_cycle_strobe_n && cnt >= waitCycles;
		dataIn <= bus_cycle_strobe_n ? ~dataIn : addrOut ^ 16'h5a5a;
	end
	// Written data is latched on the rising write strobe.
	always @(posedge write_strobe_n) begin
		if (dataOe) wrCapt <= dataOut;
	end
endmodule

// File: test/external_bus_strobe_control_asserts.sv
// Port-level checker for the external bus strobe control block.
`timescale 1ns/100ps
module strobe_ctrl_checker (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        reqAccept,
	input wire logic        reqWrite,
	input wire logic [1:0]  reqSpace,
	input wire logic        reqGlobal,
	input wire logic        modeWrite,
	input wire logic [15:0] modeWrData,
	input wire logic [15:0] modeReg,
	input wire logic        flagSet,
	input wire logic        flagClear,
	input wire logic        output_float_n,
	input wire logic        dataOe,
	input wire logic        addrOe,
	input wire logic        readPinOut,
	input wire logic        write_strobe_n,
	input wire logic        bus_cycle_strobe_n,
	input wire logic        transfer_direction,
	input wire logic        program_space_select_n,
	input wire logic        data_space_select_n,
	input wire logic        io_space_select_n,
	input wire logic        memCtrlOe,
	input wire logic        busReqOe,
	input wire logic        global_bus_request_n,
	input wire logic        hold_acknowledge_n,
	input wire logic        holdAckOe,
	input wire logic        external_flag_out,
	input wire logic        flagOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	rdwr_excl_a: assert property (!modeReg[15] |-> readPinOut || write_strobe_n)
		else $error("read and write strobes low together.");
	wr_drive_a: assert property (!write_strobe_n |-> dataOe && !transfer_direction)
		else $error("write strobe without data drive.");
	wr_cycle_a: assert property (!write_strobe_n |-> !bus_cycle_strobe_n)
		else $error("write strobe outside bus cycle.");
	sel_single_a: assert property ($onehot0(~{io_space_select_n, data_space_select_n,
		program_space_select_n}))
		else $error("more than one space select low.");
	float_off_a: assert property ($fell(output_float_n) |-> ##[1:6]
		!(memCtrlOe || busReqOe || holdAckOe || flagOe))
		else $error("outputs not floated.");
	hold_order_a: assert property ($fell(hold_acknowledge_n) |->
		!(addrOe || dataOe || memCtrlOe) && !$past(memCtrlOe))
		else $error("hold acknowledged before float.");
	flag_set_a: assert property (flagSet |=> external_flag_out)
		else $error("flag not set.");
	flag_clr_a: assert property (flagClear && !flagSet |=> !external_flag_out)
		else $error("flag not cleared.");
	mode_wr_a: assert property (modeWrite |=> modeReg == $past(modeWrData))
		else $error("mode register not written.");
	br_global_a: assert property (reqAccept && $past(reqGlobal) && $past(reqSpace) == 2'h1
		|-> !global_bus_request_n)
		else $error("bus request missing.");
	wr_pulse_a: assert property (reqAccept && $past(reqWrite) |-> ##[1:40] !write_strobe_n)
		else $error("write strobe missing.");
endmodule
bind external_bus_strobe_control strobe_ctrl_checker i_strobe_ctrl_checker (.*);

// File: test/test_external_bus_strobe_control.sv
// Self-checking testbench for the external bus strobe control block.
`timescale 1ns/100ps
module test_external_bus_strobe_control;
	logic clk, nrst, reqValid, reqWrite, reqGlobal, reqAccept, reqDone, modeWrite, flagSet;
	logic flagClear, branchOp, branchValid, branchTaken, ready, holdReq_n, output_float_n;
	logic branch_condition_in_n, dataOe, addrOe, readPinOut, write_strobe_n, bus_cycle_strobe_n;
	logic transfer_direction, program_space_select_n, data_space_select_n, io_space_select_n;
	logic memCtrlOe, global_bus_request_n, busReqOe, hold_acknowledge_n, holdAckOe, flagOe;
	logic external_flag_out;
	logic [1:0]  reqSpace;
	logic [3:0]  waitCycles;
	logic [15:0] reqAddr, reqWrData, rdData, modeWrData, modeReg, branchTarget, seqAddr;
	logic [15:0] nextAddr, dataIn, dataOut, addrOut, wrCapt;
	int          numErrors, totalChecks, cycles;
	external_bus_strobe_control i_external_bus_strobe_control (.*);
	ext_mem_model i_ext_mem_model (.*);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			numErrors++;
			summarize();
		end
	end
	task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
		totalChecks++;
		if (s !== e) begin
			numErrors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic busOp(input logic w, input logic [1:0] sp, input logic gl, input logic [15:0] a);
		int n;
		logic sawW, sawR;
		logic [2:0] expSel;
		sawW = 0;
		sawR = 0;
		n = 0;
		expSel = ~(3'b001 << sp);
		@(posedge clk);
		reqValid <= 1;
		reqWrite <= w;
		reqSpace <= sp;
		reqGlobal <= gl;
		reqAddr <= a;
		reqWrData <= ~a;
		do begin
			@(negedge clk);
			n++;
		end while (reqAccept !== 1'b1 && n < 40);
		check("select", {io_space_select_n, data_space_select_n, program_space_select_n}, expSel);
		check("addr", addrOut, a);
		check("dir", transfer_direction, !w);
		check("busreq", global_bus_request_n, !(gl && sp == 2'h1));
		check("cycle", bus_cycle_strobe_n, 0);
		@(posedge clk) reqValid <= 0;
		do begin
			@(negedge clk);
			n++;
			if (write_strobe_n === 1'b0) sawW = 1;
			if (readPinOut === 1'b0) sawR = 1;
		end while (reqDone !== 1'b1 && n < 80);
		check("wstrobe", sawW, w);
		check("rstrobe", sawR, !w);
		if (w) check("wdata", wrCapt, ~a);
		else check("rdata", rdData, a ^ 16'h5a5a);
		repeat (8) @(negedge clk);
		check("idle", bus_cycle_strobe_n, 1);
	endtask
	task automatic flagTest(input logic s, input logic c, input logic e);
		@(posedge clk);
		flagSet <= s;
		flagClear <= c;
		@(posedge clk);
		flagSet <= 0;
		flagClear <= 0;
		@(negedge clk) check("flag", external_flag_out, e);
	endtask
	task automatic branchTest(input logic v);
		@(posedge clk) branch_condition_in_n <= v;
		repeat (8) @(posedge clk);
		branchOp <= 1;
		branchTarget <= 16'h1234;
		seqAddr <= 16'h0101;
		@(posedge clk) branchOp <= 0;
		@(negedge clk) check("bvalid", branchValid, 1);
		check("taken", branchTaken, !v);
		check("target", nextAddr, v ? 16'h0101 : 16'h1234);
	endtask
	task automatic pinTest(input logic hold);
		@(posedge clk);
		holdReq_n <= !hold;
		output_float_n <= hold;
		repeat (10) @(negedge clk);
		check("hold_acknowledge_n", hold_acknowledge_n, !hold);
		check("ctrlOe", {addrOe, dataOe, memCtrlOe}, 0);
		check("otherOe", {busReqOe, holdAckOe, flagOe}, hold ? 3'h3 : 3'h0);
		@(posedge clk);
		holdReq_n <= 1;
		output_float_n <= 1;
		repeat (10) @(negedge clk);
		check("back", {hold_acknowledge_n, memCtrlOe}, 3);
	endtask
	task automatic modeTest(input logic b);
		@(posedge clk);
		modeWrite <= 1;
		modeWrData <= {b, 15'h0000};
		@(posedge clk) modeWrite <= 0;
		repeat (2) @(negedge clk);
		check("mode", modeReg, {b, 15'h0000});
		check("rdpin", readPinOut, !b);
	endtask
	initial begin
		{clk, nrst, reqValid, reqWrite, reqGlobal, modeWrite, flagSet, flagClear, branchOp} = 0;
		{holdReq_n, output_float_n, branch_condition_in_n} = 3'h7;
		{reqSpace, reqAddr, reqWrData, modeWrData, branchTarget, seqAddr} = 0;
		{numErrors, totalChecks, cycles} = 0;
		waitCycles = 4'h4;
		repeat (9) @(posedge clk);
		@(negedge clk);
		check("rstOe", {memCtrlOe, dataOe}, 0);
		check("rstMode", modeReg, 0);
		@(posedge clk);
		nrst <= 1;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			waitCycles = i[0] ? 4'h9 : 4'h4;
			busOp(i[2], i[1:0], 1'b1, 16'h0f31 + 16'(i));
		end
		modeTest(1);
		busOp(0, 2'h1, 1'b0, 16'h8001);
		busOp(1, 2'h2, 1'b0, 16'h7ffe);
		modeTest(0);
		flagTest(1, 0, 1);
		flagTest(0, 1, 0);
		flagTest(1, 1, 1);
		branchTest(0);
		branchTest(1);
		pinTest(1);
		pinTest(0);
		summarize();
	end
endmodule
